/* File: rad_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef RAD_REGS_SVH
`define RAD_REGS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define RAD_CTRL_OFS        8'h00
`define RAD_STAT_OFS        8'h04
// ****************************************
// Control fields and reset value
// ****************************************
`define RAD_CTRL_OVR_BIT    0
`define RAD_CTRL_MODE_LSB   1
`define RAD_CTRL_DLY_LSB    3
`define RAD_CTRL_RST        5'h00
// ****************************************
// Status fields
// ****************************************
`define RAD_STAT_MODE_LSB   0
`define RAD_STAT_DRV_LSB    2
`define RAD_STAT_RXEN_LSB   4
`define RAD_STAT_CFGERR_BIT 6
`define RAD_STAT_LVL0_LSB   8
`define RAD_STAT_LVL1_LSB   16
// ****************************************
// Timing
// ****************************************
`define RAD_CLK_MHZ         250
`define RAD_TURN_SHORT_US   10
`define RAD_TURN_LONG_US    50
`define RAD_SHORT_CYC       (`RAD_TURN_SHORT_US * `RAD_CLK_MHZ)
`define RAD_LONG_CYC        (`RAD_TURN_LONG_US * `RAD_CLK_MHZ)
`define RAD_FIFO_DEPTH      32
// Synchroniser reset value: line levels idle high, switches off
`define RAD_SYNC_RST        11'h00f
`endif

/* File: rad_pkg.sv */
// Types shared by the direction-control block
package rad_pkg;
  // Operating mode, two-bit code
  typedef enum logic [1:0] {
    mode_rs422 = 2'b00,
    mode_4wire = 2'b01,
    mode_2wire = 2'b11
  } rad_mode_e;
  // Per-port driver state, Gray coded along idle-drive-hold
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_drive = 2'b01,
    st_hold  = 2'b11
  } rad_state_e;
endpackage

/* File: rad_isolator.sv */
// Two-port RS422/RS485 repeater direction control with FIFO and APB
// Operation
// - Three modes chosen by static switch inputs
// - Switch one/two decode mode; others fixed
// - RS422 keeps drivers and receivers always enabled
// - 4-wire: driver auto on/off, receiver always on
// - 2-wire: receiver off while driver enabled
// - Driver on at once, off after turnaround
// - Per-port switch picks 10 or 50 us
// - Each port has independent direction control
// - RS422 relays data and handshake transparently
//
// Decided for this implementation: the APB register port and the register addresses.
`include "rad_regs.svh"

// ****************************************
// FIFO with valid/ready on both sides
// ****************************************
module rad_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = `RAD_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     ce_in,
  // Fill side
  input  wire logic                     in_valid_in,
  output logic                          in_ready_out,
  input  wire logic [WIDTH-1:0]         in_data_in,
  // Drain side
  output logic                          out_valid_out,
  input  wire logic                     out_ready_in,
  output logic [WIDTH-1:0]              out_data_out,
  // Fill level
  output logic [$clog2(DEPTH):0]        level_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];        // Storage words
  logic [AW:0]      wr_r, wr_nxt;       // Write pointer with wrap bit
  logic [AW:0]      rd_r, rd_nxt;       // Read pointer with wrap bit
  logic             push, pop;          // Accepted transfers

  // Full when pointers differ only in the wrap bit
  assign in_ready_out  = (wr_r - rd_r) != (AW + 1)'(DEPTH);
  assign out_valid_out = wr_r != rd_r;
  assign out_data_out  = mem[rd_r[AW-1:0]];
  assign level_out     = wr_r - rd_r;
  assign push          = ce_in & in_valid_in & in_ready_out;
  assign pop           = ce_in & out_valid_out & out_ready_in;

  // Pointer next values
  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
  end

  // Pointer registers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_in;
    end
  end
endmodule // rad_fifo

// ****************************************
// Top: two ports, mode decode, APB slave
// ****************************************
module rad_isolator #(
  parameter int SHORT_CYC  = `RAD_SHORT_CYC,
  parameter int LONG_CYC   = `RAD_LONG_CYC,
  parameter int FIFO_DEPTH = `RAD_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  // Configuration switches (static pins)
  input  wire logic        two_wire_select_switch_in,
  input  wire logic        bus_mode_select_switch_in,
  input  wire logic        mode_switch_three_off_in,
  input  wire logic        mode_switch_four_on_in,
  input  wire logic        mode_switch_five_off_in,
  input  wire logic [1:0]  turnaround_delay_select_in,
  // Line side, one bit per port
  input  wire logic [1:0]  line_rx_in,
  input  wire logic [1:0]  line_hs_in,
  output logic      [1:0]  line_tx_out,
  output logic      [1:0]  line_hs_out,
  output logic      [1:0]  line_drv_oe_n_out,
  output logic      [1:0]  line_rx_en_out,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic      [31:0] prdata_out,
  output logic             pslverr_out
);
  localparam int CW = $clog2(LONG_CYC + 1);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Mode decode from the two selecting switches
  function automatic rad_pkg::rad_mode_e decode_mode(input logic sw1,
                                                     input logic sw2);
    if (sw2 & sw1) begin
      decode_mode = rad_pkg::mode_2wire;
    end else if (sw2) begin
      decode_mode = rad_pkg::mode_4wire;
    end else begin
      decode_mode = rad_pkg::mode_rs422;
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [10:0] pins;                    // Raw pin vector
  logic [10:0] s1_r, s2_r, s3_r;        // Three-stage chain
  logic [10:0] stab_r, stab_nxt;        // Accepted pin levels

  assign pins = {mode_switch_five_off_in, mode_switch_four_on_in,
                 mode_switch_three_off_in, bus_mode_select_switch_in,
                 two_wire_select_switch_in, turnaround_delay_select_in,
                 line_hs_in, line_rx_in};

  // Take a bit once the second and third stages agree
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      stab_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stab_r[i];
    end
  end

  // Synchroniser registers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_r   <= `RAD_SYNC_RST;
      s2_r   <= `RAD_SYNC_RST;
      s3_r   <= `RAD_SYNC_RST;
      stab_r <= `RAD_SYNC_RST;
    end else if (ce_in) begin
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      stab_r <= stab_nxt;
    end
  end

  // ****************************************
  // Configuration
  // ****************************************
  logic [4:0]         ctrl_r, ctrl_nxt;  // Software override control
  rad_pkg::rad_mode_e mode;              // Effective mode
  logic [1:0]         dly_short;         // Per-port short delay select
  logic               cfg_err;           // Switch combination unusable
  logic [1:0]         rx_raw, hs_raw;    // Synchronised line levels

  assign rx_raw = stab_r[1:0];
  assign hs_raw = stab_r[3:2];
  // Software may override the switches; otherwise switches rule
  assign mode = ctrl_r[`RAD_CTRL_OVR_BIT] ?
      decode_mode(ctrl_r[`RAD_CTRL_MODE_LSB],
                  ctrl_r[`RAD_CTRL_MODE_LSB+1]) :
      decode_mode(stab_r[6], stab_r[7]);
  assign dly_short = ctrl_r[`RAD_CTRL_OVR_BIT] ?
      ctrl_r[`RAD_CTRL_DLY_LSB +: 2] : stab_r[5:4];
  // Fixed switches out of place, or switch one without two
  assign cfg_err = (stab_r[6] & ~stab_r[7]) | stab_r[8] |
                   ~stab_r[9] | stab_r[10];

  // ****************************************
  // Receive side and FIFOs (port p feeds port 1-p)
  // ****************************************
  logic [1:0] last_r [2];               // Last word pushed per port
  logic [1:0] last_nxt [2];
  logic [1:0] word [2];                 // Current receive word
  logic [1:0] f_in_valid, f_in_ready;   // Fill handshakes
  logic [1:0] f_out_valid, f_out_ready; // Drain handshakes
  logic [1:0] f_out_data [2];           // Words leaving each FIFO
  logic [LW-1:0] f_level [2];           // Fill levels
  logic [1:0] rx_en_r, rx_en_nxt;       // Receiver enables

  // Build words; a blanked receiver reads idle, handshake only in RS422
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      word[p][0] = rx_en_r[p] ? rx_raw[p] : 1'b1;
      word[p][1] = (mode == rad_pkg::mode_rs422) ?
                   hs_raw[p] : 1'b1;
      f_in_valid[p] = word[p] != last_r[p];
      // A refused change stays pending and is offered again
      last_nxt[p] = (f_in_valid[p] & f_in_ready[p]) ? word[p] : last_r[p];
    end
  end

  // Last pushed word registers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      last_r[0] <= 2'h3;
      last_r[1] <= 2'h3;
    end else if (ce_in) begin
      last_r[0] <= last_nxt[0];
      last_r[1] <= last_nxt[1];
    end
  end

  // One FIFO per direction
  for (genvar g = 0; g < 2; g++) begin : g_fifo
    rad_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_in    (ref_clk_in),
      .reset_in      (reset_in),
      .ce_in         (ce_in),
      .in_valid_in   (f_in_valid[g]),
      .in_ready_out  (f_in_ready[g]),
      .in_data_in    (word[g]),
      .out_valid_out (f_out_valid[g]),
      .out_ready_in  (f_out_ready[g]),
      .out_data_out  (f_out_data[g]),
      .level_out     (f_level[g])
    );
  end

  // ****************************************
  // Transmit side, per-port direction control
  // ****************************************
  rad_pkg::rad_state_e st_r [2];        // Driver state per port
  rad_pkg::rad_state_e st_nxt [2];
  logic [CW-1:0] cnt_r [2];             // Turnaround countdown
  logic [CW-1:0] cnt_nxt [2];
  logic [1:0] tx_r, tx_nxt;             // Line data out
  logic [1:0] hs_r, hs_nxt;             // Line handshake out
  logic [1:0] drv_r, drv_nxt;           // Driver enable, active high

  // Port q drains the FIFO of port 1-q
  always_comb begin
    for (int q = 0; q < 2; q++) begin
      // 2-wire: hold off while the bus is busy and our driver is off
      f_out_ready[1-q] = ~((mode == rad_pkg::mode_2wire) &
                           (st_r[q] == rad_pkg::st_idle) & ~rx_raw[q]);
      tx_nxt[q] = tx_r[q];
      hs_nxt[q] = hs_r[q];
      if (f_out_valid[1-q] & f_out_ready[1-q]) begin
        tx_nxt[q] = f_out_data[1-q][0];
        hs_nxt[q] = (mode == rad_pkg::mode_rs422) ?
                    f_out_data[1-q][1] : 1'b1;
      end
      st_nxt[q]  = st_r[q];
      cnt_nxt[q] = cnt_r[q];
      if (mode == rad_pkg::mode_rs422) begin
        st_nxt[q] = rad_pkg::st_idle;
      end else begin
        case (st_r[q])
          rad_pkg::st_idle: begin
            if (~tx_nxt[q]) begin
              st_nxt[q] = rad_pkg::st_drive;
            end
          end
          rad_pkg::st_drive: begin
            if (tx_nxt[q]) begin
              st_nxt[q]  = rad_pkg::st_hold;
              cnt_nxt[q] = dly_short[q] ? CW'(SHORT_CYC - 1) :
                                          CW'(LONG_CYC - 1);
            end
          end
          rad_pkg::st_hold: begin
            if (~tx_nxt[q]) begin
              st_nxt[q] = rad_pkg::st_drive;
            end else if (cnt_r[q] == '0) begin
              st_nxt[q] = rad_pkg::st_idle;
            end else begin
              cnt_nxt[q] = cnt_r[q] - 1'b1;
            end
          end
          default: begin
            st_nxt[q] = rad_pkg::st_idle;
          end
        endcase
      end
      // RS422 always drives; RS485 drives while not idle
      drv_nxt[q] = (mode == rad_pkg::mode_rs422) |
                   (st_nxt[q] != rad_pkg::st_idle);
      // Receiver blanked only in 2-wire while driving
      rx_en_nxt[q] = ~((mode == rad_pkg::mode_2wire) &
                       drv_nxt[q]);
    end
  end

  // Transmit and direction registers, one set per port
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int q = 0; q < 2; q++) begin
        st_r[q]  <= rad_pkg::st_idle;
        cnt_r[q] <= '0;
      end
      tx_r    <= 2'h3;
      hs_r    <= 2'h3;
      drv_r   <= 2'h0;
      rx_en_r <= 2'h3;
    end else if (ce_in) begin
      for (int q = 0; q < 2; q++) begin
        st_r[q]  <= st_nxt[q];
        cnt_r[q] <= cnt_nxt[q];
      end
      tx_r    <= tx_nxt;
      hs_r    <= hs_nxt;
      drv_r   <= drv_nxt;
      rx_en_r <= rx_en_nxt;
    end
  end

  assign line_tx_out       = tx_r;
  assign line_hs_out       = hs_r;
  assign line_drv_oe_n_out = ~drv_r;
  assign line_rx_en_out    = rx_en_r;

  // ****************************************
  // APB slave, zero wait states while ce_in is high
  // ****************************************
  logic        setup, wr_acc;           // Phase decodes
  logic [31:0] rd_nxt, prdata_r;        // Read data
  logic        err_nxt, err_r;          // Unmapped address answer
  logic [31:0] stat;                    // Status word

  assign setup  = psel_in & ~penable_in;
  assign wr_acc = psel_in & penable_in & pwrite_in & ~err_r;
  always_comb begin
    stat = '0;
    stat[`RAD_STAT_MODE_LSB +: 2] = mode;
    stat[`RAD_STAT_DRV_LSB +: 2]  = drv_r;
    stat[`RAD_STAT_RXEN_LSB +: 2] = rx_en_r;
    stat[`RAD_STAT_CFGERR_BIT]    = cfg_err;
    stat[`RAD_STAT_LVL0_LSB +: LW] = f_level[0];
    stat[`RAD_STAT_LVL1_LSB +: LW] = f_level[1];
  end

  // Decode in setup phase, write in access phase
  always_comb begin
    rd_nxt   = prdata_r;
    err_nxt  = err_r;
    ctrl_nxt = ctrl_r;
    if (setup) begin
      rd_nxt  = '0;
      err_nxt = 1'b0;
      if (paddr_in == `RAD_CTRL_OFS) begin
        rd_nxt[4:0] = ctrl_r;
      end else if (paddr_in == `RAD_STAT_OFS) begin
        rd_nxt = stat;
      end else begin
        err_nxt = 1'b1;
      end
    end
    if (wr_acc & (paddr_in == `RAD_CTRL_OFS)) begin
      ctrl_nxt = pwdata_in[4:0];
    end
  end

  // APB registers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_r <= '0;
      err_r    <= 1'b0;
      ctrl_r   <= `RAD_CTRL_RST;
    end else if (ce_in) begin
      prdata_r <= rd_nxt;
      err_r    <= err_nxt;
      ctrl_r   <= ctrl_nxt;
    end
  end

  assign pready_out  = ce_in;
  assign prdata_out  = prdata_r;
  assign pslverr_out = err_r & psel_in & penable_in;
endmodule // rad_isolator

/* File: rad_isolator_assertions.sv */
// Port-level checker for the direction-control block
module rad_isolator_assertions #(
  parameter int SHORT_CYC = 4
) (
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  input wire logic        ce_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic        pslverr_out,
  input wire logic [1:0]  line_tx_out,
  input wire logic [1:0]  line_drv_oe_n_out,
  input wire logic [1:0]  line_rx_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Idle-high run length per outgoing line, saturating
  logic [7:0] hi_r   [2];
  logic [7:0] hi_nxt [2];
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (!line_tx_out[p]) begin
        hi_nxt[p] = 8'h00;
      end else if (hi_r[p] != 8'hff) begin
        hi_nxt[p] = hi_r[p] + 8'h01;
      end else begin
        hi_nxt[p] = hi_r[p];
      end
    end
  end
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hi_r <= '{8'h00, 8'h00};
    end else begin
      hi_r <= hi_nxt;
    end
  end
  // Bus transfer phases
  sequence s_access;
    psel_in && penable_in;
  endsequence
  sequence s_bad_addr;
    paddr_in != 8'h00 && paddr_in != 8'h04;
  endsequence
  a_drv_on_p0: assert property ($fell(line_tx_out[0]) |->
    !line_drv_oe_n_out[0]) else $error("port 0 driver late");
  a_drv_on_p1: assert property ($fell(line_tx_out[1]) |->
    !line_drv_oe_n_out[1]) else $error("port 1 driver late");
  a_drv_held_low: assert property (
    (~line_tx_out & line_drv_oe_n_out) == 2'b00)
    else $error("driver off while data active");
  a_rx_blank_only: assert property (
    (line_drv_oe_n_out & ~line_rx_en_out) == 2'b00)
    else $error("receiver off with driver idle");
  a_turn_min_p0: assert property ($rose(line_drv_oe_n_out[0]) |->
    hi_r[0] >= SHORT_CYC) else $error("port 0 turnaround short");
  a_turn_min_p1: assert property ($rose(line_drv_oe_n_out[1]) |->
    hi_r[1] >= SHORT_CYC) else $error("port 1 turnaround short");
  a_pready_ce: assert property (s_access |-> pready_out == ce_in)
    else $error("pready not following enable");
  a_unmapped_err: assert property (s_access and s_bad_addr |->
    pslverr_out && prdata_out == 32'h0) else $error("unmapped not refused");
endmodule // rad_isolator_assertions

bind rad_isolator rad_isolator_assertions #(.SHORT_CYC(SHORT_CYC)) chk (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
  .pready_out(pready_out), .prdata_out(prdata_out),
  .pslverr_out(pslverr_out), .line_tx_out(line_tx_out),
  .line_drv_oe_n_out(line_drv_oe_n_out), .line_rx_en_out(line_rx_en_out));

/* File: rad_line_partner.sv */
// Far-side serial nodes on both ports
module rad_line_partner #(
  parameter int BIT_CYC = 3
) (
  input  wire logic       ref_clk_in,
  input  wire logic [1:0] drv_oe_n_in,
  input  wire logic [1:0] tx_in,
  input  wire logic       echo_in,
  output logic      [1:0] rx_out,
  output logic      [1:0] hs_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lvl_r = 2'b11; // Node levels, idle high on termination
  logic [1:0] hs_r  = 2'b11; // Handshake levels, idle high
  // Shared 2-wire pair carries the block's own drive back to it
  assign rx_out = lvl_r & ~({2{echo_in}} & ~drv_oe_n_in & ~tx_in);
  assign hs_out = hs_r;
  // Bit time kept below the short turnaround, so gaps restart it
  task automatic send_frame(input int p, input logic [9:0] bits);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk_in);
      lvl_r[p] <= bits[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk_in);
    end
    @(posedge ref_clk_in);
    lvl_r[p] <= 1'b1;
  endtask
  task automatic set_hs(input int p, input logic v);
    @(posedge ref_clk_in);
    hs_r[p] <= v;
  endtask
endmodule // rad_line_partner

/* File: tb_rad_isolator.sv */
// Self-checking bench for the direction-control block
module tb_rad_isolator;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S_CYC = 4;
  localparam int L_CYC = 20;
  logic        clk, rst, ce, sw1, sw2, sw3, sw4, sw5, echo;
  logic        psel, pen, pwr, pready, pslverr, err;
  logic [1:0]  dsel, rx, hs, tx, hso, oe_n, rx_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_fail, n_compared;
  rad_isolator #(.SHORT_CYC(S_CYC), .LONG_CYC(L_CYC)) dut (
    .ref_clk_in(clk), .reset_in(rst), .ce_in(ce),
    .two_wire_select_switch_in(sw1), .bus_mode_select_switch_in(sw2),
    .mode_switch_three_off_in(sw3), .mode_switch_four_on_in(sw4),
    .mode_switch_five_off_in(sw5), .turnaround_delay_select_in(dsel),
    .line_rx_in(rx), .line_hs_in(hs), .line_tx_out(tx),
    .line_hs_out(hso), .line_drv_oe_n_out(oe_n), .line_rx_en_out(rx_en),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr));
  rad_line_partner part (.ref_clk_in(clk), .drv_oe_n_in(oe_n),
    .tx_in(tx), .echo_in(echo), .rx_out(rx), .hs_out(hs));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("Compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // Mode decode from the switch pins, plus a misplaced fixed switch
  task automatic t_pins;
    logic [3:0] tbl [3] = '{4'b0000, 4'b0101, 4'b1111};
    apb(1'b0, 8'h08, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", q, 32'h0);
    for (int i = 0; i < 3; i++) begin
      sw1 <= tbl[i][3];
      sw2 <= tbl[i][2];
      repeat (8) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      check("mode", q[1:0], tbl[i][1:0]);
      check("cfg error", q[6], 1'b0);
    end
    sw3 <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    check("cfg error", q[6], 1'b1);
    sw1 <= 1'b0;
    sw2 <= 1'b0;
    sw3 <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // Transparent relay of handshake and data in RS422 mode
  task automatic t_rs422;
    int   falls;
    logic prev;
    falls = 0;
    check("drivers on", oe_n, 2'b00);
    check("receivers on", rx_en, 2'b11);
    part.set_hs(0, 1'b0);
    repeat (12) @(negedge clk);
    check("handshake relay", hso[1], 1'b0);
    part.set_hs(0, 1'b1);
    fork
      part.send_frame(0, 10'h2aa);
    join_none
    prev = tx[1];
    repeat (45) begin
      @(negedge clk);
      if (tx[1] === 1'b0 && prev === 1'b1) falls++;
      prev = tx[1];
    end
    check("relayed zeros", falls, 5);
    check("drivers still on", oe_n, 2'b00);
  endtask
  // Clock enable low freezes every flop and drops pready
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    sw2 <= 1'b1;
    repeat (8) @(posedge clk);
    check("pready frozen", pready, 1'b0);
    check("drivers frozen", oe_n, 2'b00);
    ce <= 1'b1;
    sw2 <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // Mid-run reset: pin levels while held, CTRL cleared after release
  task automatic t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check("tx at reset", tx, 2'b11);
    check("hs at reset", hso, 2'b11);
    check("oe_n at reset", oe_n, 2'b11);
    check("rx_en at reset", rx_en, 2'b11);
    check("pready at reset", pready, 1'b1);
    check("prdata at reset", prdata, 32'h0);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl after reset", q, 32'h0);
    check("drivers after reset", oe_n, 2'b00);
  endtask
  // Frame on port p; judge the driver of the other port
  task automatic run_frame(input int p, input int exp, input logic two);
    int qp, cnt, n;
    qp = 1 - p;
    cnt = 0;
    n = 0;
    fork
      part.send_frame(p, 10'h2aa);
    join_none
    while (oe_n[qp] !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60) begin
      n_fail++;
      report_and_stop();
    end
    check("data at driver on", tx[qp], 1'b0);
    while (oe_n[qp] !== 1'b1 && n < 400) begin
      check("rx enable", rx_en[qp], !two);
      if (tx[qp] === 1'b0) cnt = 0;
      else cnt++;
      @(negedge clk);
      n++;
    end
    check("turnaround", cnt, exp);
    check("rx back on", rx_en[qp], 1'b1);
    if (n >= 400) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  initial begin
    {rst, ce, sw4} = 3'b111;
    {sw1, sw2, sw3, sw5, echo, psel, pen, pwr} = '0;
    dsel = 2'b11;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_pins();
    t_rs422();
    t_freeze();
    apb(1'b1, 8'h00, 32'h1d);
    repeat (10) @(posedge clk);
    run_frame(0, S_CYC, 1'b0);
    run_frame(1, S_CYC, 1'b0);
    echo <= 1'b1;
    apb(1'b1, 8'h00, 32'h0f);
    repeat (10) @(posedge clk);
    run_frame(0, L_CYC, 1'b1);
    run_frame(1, S_CYC, 1'b1);
    t_reset();
    report_and_stop();
  end
endmodule // tb_rad_isolator
